// *** hw/snp_consts.svh ***
// Constants for the serial nonvolatile memory command block.
`ifndef SNP_CONSTS_SVH
`define SNP_CONSTS_SVH
`define SNP_OP_SET_LATCH 8'h06
`define SNP_OP_CLR_LATCH 8'h04
`define SNP_OP_RD_STAT 8'h05
`define SNP_OP_WR_STAT 8'h01
`define SNP_OP_MEM_RD 3'h3
`define SNP_OP_MEM_WR 3'h2
`define SNP_OP_ATOP_POS 3
`define SNP_ST_BP_HI 3
`define SNP_ST_BP_LO 2
`define SNP_ST_LATCH 1
`define SNP_ADDR_Q_LIMIT 9'h180
`define SNP_ADDR_H_LIMIT 9'h100
`define SNP_ADDR_LAST 9'h1FF
`define SNP_ADDR_FIRST 9'h000
`define SNP_PINS_RST 5'h0B
`define SNP_BP_RST 2'h0
`define SNP_CNT_LAST 3'h7
`endif

// *** hw/snp_pkg.sv ***
// Types shared by the serial nonvolatile memory command block.
package snp_pkg;
    typedef enum logic [2:0] {
        SNP_IDLE = 3'h0,
        SNP_OPCODE = 3'h1,
        SNP_ADDR = 3'h3,
        SNP_RDATA = 3'h2,
        SNP_WDATA = 3'h6,
        SNP_SREAD = 3'h7,
        SNP_SWRITE = 3'h5,
        SNP_IGNORE = 3'h4
    } snp_state_t;
    typedef struct packed {
        logic sck;
        logic cs_n;
        logic si;
        logic pause_n;
        logic wp_n;
    } snp_pins_t;
endpackage : snp_pkg

// *** hw/snp_top.sv ***
// Serial nonvolatile memory slave: commands, protection and burst access.
//
// Function
// - Protect bits choose blocked array range.
// - Writes need latch set and protect pin high.
// - Block ranges apply only when writes enabled.
// - Status read repeats current status byte.
// - Status write clears latch afterwards.
// - Write address: opcode bit three plus byte.
// - Write address increments, wraps at top.
// - Each full byte commits at eighth bit.
// - Protected address stops burst and address.
// - Select rise ends a write.
// - Read address taken alike, then data out.
// - Read bytes MSB first, address wraps.
// - Select rise ends read, output released.
// - Pause pin freezes operation while clock low.
// - First byte decodes as opcode.
// - Status byte layout, other bits zero.
// - Latch set only by set command.
// - Clock level at select fall picks mode.
`timescale 1ns/1ns
`include "snp_consts.svh"
module snp_top #(
    parameter int ADDR_W = 9,
    parameter int DEPTH = 512
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic spi_sck_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_si_i,
    input wire logic spi_pause_n_i,
    input wire logic wp_n_i,
    output logic spi_so_o,
    output logic spi_so_oe_o,
    output logic spi_mode3_o,
    output logic [7:0] status_o
);
    snp_pkg::snp_pins_t pin_in;
    snp_pkg::snp_pins_t s1_q;
    snp_pkg::snp_pins_t s2_q;
    snp_pkg::snp_pins_t s3_q;
    snp_pkg::snp_pins_t filt_q;
    snp_pkg::snp_pins_t prev_q;
    snp_pkg::snp_state_t state_q;
    logic [7:0] mem_q [DEPTH];
    logic [2:0] cnt_q;
    logic [7:0] rx_q;
    logic [7:0] rx_byte;
    logic [ADDR_W-1:0] addr_q;
    logic [1:0] bp_q;
    logic write_enable_latch_q;
    logic wr_op_q;
    logic stopped_q;
    logic paused_q;
    logic cs_fall;
    logic cs_rise;
    logic sel;
    logic rise;
    logic fall;
    logic byte_done;
    logic write_ok;
    logic addr_prot;
    logic mem_we;
    logic [7:0] status_byte;
    logic [7:0] tx_byte;
    localparam logic [4:0] PINS_RST = `SNP_PINS_RST;

    assign pin_in = '{sck: spi_sck_i, cs_n: spi_cs_n_i, si: spi_si_i,
                      pause_n: spi_pause_n_i, wp_n: wp_n_i};

    // Three stage sampling of the pins; a level is accepted only once
    // the second and third stages agree, which rejects single glitches.
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s1_q <= `SNP_PINS_RST;
            s2_q <= `SNP_PINS_RST;
            s3_q <= `SNP_PINS_RST;
            prev_q <= `SNP_PINS_RST;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            prev_q <= filt_q;
        end
    end

    for (genvar g = 0; g < 5; g++) begin : g_filt
        always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                filt_q[g] <= PINS_RST[g];
            end else if (s2_q[g] == s3_q[g]) begin
                filt_q[g] <= s2_q[g];
            end
        end
    end

    assign sel = !filt_q.cs_n;
    assign cs_fall = prev_q.cs_n && !filt_q.cs_n;
    assign cs_rise = !prev_q.cs_n && filt_q.cs_n;
    // Clock edges are ignored while paused, so the transfer freezes.
    assign rise = sel && !paused_q && !prev_q.sck && filt_q.sck;
    assign fall = sel && !paused_q && prev_q.sck && !filt_q.sck;
    assign byte_done = rise && (cnt_q == `SNP_CNT_LAST);
    assign rx_byte = {rx_q[6:0], filt_q.si};

    assign write_ok = write_enable_latch_q && filt_q.wp_n;

    always_comb begin
        unique case (bp_q)
            2'h0: addr_prot = 1'b0;
            2'h1: addr_prot = addr_q >= `SNP_ADDR_Q_LIMIT;
            2'h2: addr_prot = addr_q >= `SNP_ADDR_H_LIMIT;
            2'h3: addr_prot = 1'b1;
        endcase
    end

    assign mem_we = byte_done && state_q == snp_pkg::SNP_WDATA
        && write_ok && !addr_prot && !stopped_q;
    assign status_byte = {4'h0, bp_q, write_enable_latch_q, 1'b0};
    assign tx_byte = (state_q == snp_pkg::SNP_SREAD) ? status_byte
        : mem_q[addr_q];

    // Pause state only moves while the clock is low.
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            paused_q <= 1'b0;
        end else if (!filt_q.sck) begin
            paused_q <= !filt_q.pause_n;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            spi_mode3_o <= 1'b0;
        end else if (cs_fall) begin
            spi_mode3_o <= filt_q.sck;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_q <= 3'h0;
            rx_q <= 8'h00;
        end else if (!sel) begin
            cnt_q <= 3'h0;
        end else if (rise) begin
            cnt_q <= cnt_q + 3'h1;
            rx_q <= rx_byte;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= snp_pkg::SNP_IDLE;
        end else if (cs_rise || !sel) begin
            state_q <= snp_pkg::SNP_IDLE;
        end else if (cs_fall) begin
            state_q <= snp_pkg::SNP_OPCODE;
        end else if (byte_done) begin
            unique case (state_q)
                snp_pkg::SNP_OPCODE: begin
                    if (rx_byte == `SNP_OP_RD_STAT) begin
                        state_q <= snp_pkg::SNP_SREAD;
                    end else if (rx_byte == `SNP_OP_WR_STAT) begin
                        state_q <= snp_pkg::SNP_SWRITE;
                    end else if (rx_byte[7:4] == 4'h0 && (rx_byte[2:0]
                        == `SNP_OP_MEM_RD || rx_byte[2:0]
                        == `SNP_OP_MEM_WR)) begin
                        state_q <= snp_pkg::SNP_ADDR;
                    end else begin
                        state_q <= snp_pkg::SNP_IGNORE;
                    end
                end
                snp_pkg::SNP_ADDR: begin
                    state_q <= wr_op_q ? snp_pkg::SNP_WDATA
                        : snp_pkg::SNP_RDATA;
                end
                snp_pkg::SNP_SWRITE: begin
                    state_q <= snp_pkg::SNP_IGNORE;
                end
                // A status read repeats the byte, data bursts stay.
                default: begin
                    state_q <= state_q;
                end
            endcase
        end
    end

    // Marks a command that counts as a write, so the latch drops at
    // the select rise even if the write itself was refused.
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_op_q <= 1'b0;
        end else if (cs_fall) begin
            wr_op_q <= 1'b0;
        end else if (byte_done && state_q == snp_pkg::SNP_OPCODE) begin
            wr_op_q <= rx_byte == `SNP_OP_CLR_LATCH
                || rx_byte == `SNP_OP_WR_STAT
                || (rx_byte[7:4] == 4'h0
                && rx_byte[2:0] == `SNP_OP_MEM_WR);
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            write_enable_latch_q <= 1'b0;
        end else if (cs_rise && wr_op_q) begin
            write_enable_latch_q <= 1'b0;
        end else if (byte_done && state_q == snp_pkg::SNP_OPCODE
            && rx_byte == `SNP_OP_SET_LATCH) begin
            write_enable_latch_q <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bp_q <= `SNP_BP_RST;
        end else if (byte_done && state_q == snp_pkg::SNP_SWRITE
            && write_ok) begin
            bp_q <= {rx_byte[`SNP_ST_BP_HI],
                rx_byte[`SNP_ST_BP_LO]};
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            addr_q <= `SNP_ADDR_FIRST;
            stopped_q <= 1'b0;
        end else if (cs_fall) begin
            stopped_q <= 1'b0;
        end else if (byte_done) begin
            if (state_q == snp_pkg::SNP_OPCODE) begin
                addr_q[ADDR_W-1] <= rx_byte[`SNP_OP_ATOP_POS];
            end else if (state_q == snp_pkg::SNP_ADDR) begin
                addr_q[7:0] <= rx_byte;
            end else if (state_q == snp_pkg::SNP_WDATA) begin
                if (write_ok && (addr_prot || stopped_q)) begin
                    stopped_q <= 1'b1;
                end else begin
                    addr_q <= addr_q + 9'h001;
                end
            end else if (state_q == snp_pkg::SNP_RDATA) begin
                addr_q <= addr_q + 9'h001;
            end
        end
    end

    // The array has no reset: contents are meant to persist.
    always_ff @(posedge sys_clk_i) begin
        if (mem_we) begin
            mem_q[addr_q] <= rx_byte;
        end
    end

    // Output bits change on falling clock edges, MSB first.
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            spi_so_o <= 1'b0;
            spi_so_oe_o <= 1'b0;
        end else if (cs_rise || !sel) begin
            spi_so_oe_o <= 1'b0;
        end else if (fall && (state_q == snp_pkg::SNP_RDATA
            || state_q == snp_pkg::SNP_SREAD)) begin
            spi_so_o <= tx_byte[3'h7 - cnt_q];
            spi_so_oe_o <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            status_o <= 8'h00;
        end else begin
            status_o <= status_byte;
        end
    end

    a_latch_clear_end: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        cs_rise && wr_op_q |=> !write_enable_latch_q)
        else $error("latch not cleared after write command");

    a_latch_set_cause: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        $rose(write_enable_latch_q) |-> $past(byte_done)
        && $past(state_q) == snp_pkg::SNP_OPCODE
        && $past(rx_byte) == `SNP_OP_SET_LATCH)
        else $error("latch set without set command");

    a_so_release: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        cs_rise |=> !spi_so_oe_o [*2])
        else $error("output still driven after deselect");

    a_block_guard: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        mem_we |-> (bp_q == 2'h0 || (bp_q == 2'h1
        && addr_q < `SNP_ADDR_Q_LIMIT) || (bp_q == 2'h2
        && addr_q < `SNP_ADDR_H_LIMIT)) && write_enable_latch_q
        && filt_q.wp_n)
        else $error("write into protected range");

    a_addr_wrap: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        mem_we && addr_q == `SNP_ADDR_LAST
        |=> addr_q == `SNP_ADDR_FIRST)
        else $error("write address did not wrap");

    a_burst_stop: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        stopped_q && !cs_fall |=> !mem_we && $stable(addr_q))
        else $error("stopped burst still writing");

    a_bp_refuse: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        bp_q != $past(bp_q) |-> $past(write_ok)
        && $past(state_q) == snp_pkg::SNP_SWRITE)
        else $error("protect bits changed without permission");

    a_pause_freeze: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        paused_q && sel ##1 paused_q && sel |-> $stable(cnt_q))
        else $error("bit count moved while paused");

    a_mode_pick: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        cs_fall |=> spi_mode3_o == $past(filt_q.sck))
        else $error("mode not taken from clock level");

    a_status_zero: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        status_o[7:4] == 4'h0 && !status_o[0]
        && status_o[`SNP_ST_LATCH] == $past(write_enable_latch_q))
        else $error("status layout wrong");
endmodule : snp_top

// *** tb/snp_spi_master.sv ***
// Bus master model that drives the serial memory pins from the bench.
`timescale 1ns/1ns
module snp_spi_master (
    input wire logic clk_i,
    input wire logic so_i,
    output logic sck_o,
    output logic cs_n_o,
    output logic si_o,
    output logic pause_n_o,
    output logic [7:0] rx_o,
    output logic rx_valid_o
);
    logic idle_q;
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
        pause_n_o = 1'b1;
        rx_o = 8'h00;
        rx_valid_o = 1'b0;
        idle_q = 1'b0;
    end
    task automatic ticks(input int n);
        repeat (n) @(posedge clk_i);
        #2;
    endtask : ticks
    // The clock rests at the idle level of the mode before select falls.
    task automatic start(input logic m);
        idle_q = m;
        sck_o = m;
        ticks(4);
        cs_n_o = 1'b0;
        ticks(4);
    endtask : start
    task automatic stop();
        sck_o = idle_q;
        ticks(4);
        cs_n_o = 1'b1;
        // A released data line must not keep showing its last bit.
        si_o = ~si_o;
        ticks(8);
    endtask : stop
    // Read data is sampled late in the high phase, where it has settled.
    task automatic xfer(input logic [7:0] tx, input logic chk);
        logic [7:0] rx;
        rx = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            sck_o = 1'b0;
            si_o = tx[i];
            ticks(4);
            sck_o = 1'b1;
            ticks(4);
            rx[i] = so_i;
        end
        rx_o = rx;
        rx_valid_o = chk;
        ticks(1);
        rx_valid_o = 1'b0;
    endtask : xfer
    task automatic hold(input int n);
        sck_o = 1'b0;
        ticks(6);
        pause_n_o = 1'b0;
        ticks(6);
        repeat (n) begin
            sck_o = 1'b1;
            ticks(6);
            sck_o = 1'b0;
            ticks(6);
        end
        pause_n_o = 1'b1;
        ticks(6);
    endtask : hold
endmodule : snp_spi_master

// *** tb/tb.sv ***
// Self-checking bench for the serial memory command and protection block.
`timescale 1ns/1ns
`include "snp_consts.svh"
module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wp_n = 1'b1;
    logic write_enable_latch = 1'b0;
    logic [1:0] bp = 2'h0;
    logic sck, cs_n, si, pause_n, so, so_oe, mode3, rx_valid;
    logic [7:0] status, rx;
    logic [7:0] mem [512];
    logic [7:0] exp_q [$];
    int num_errors = 0;
    int check_count = 0;
    snp_top u_snp_top (.sys_clk_i(clk), .reset_n_i(rst_n), .spi_sck_i(sck),
        .spi_cs_n_i(cs_n), .spi_si_i(si), .spi_pause_n_i(pause_n),
        .wp_n_i(wp_n), .spi_so_o(so), .spi_so_oe_o(so_oe),
        .spi_mode3_o(mode3), .status_o(status));
    snp_spi_master u_snp_spi_master (.clk_i(clk), .so_i(so), .sck_o(sck),
        .cs_n_o(cs_n), .si_o(si), .pause_n_o(pause_n), .rx_o(rx),
        .rx_valid_o(rx_valid));
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic check(input string what, input logic [7:0] seen,
        input logic [7:0] want);
        check_count++;
        if (seen !== want) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, want, seen);
        end
    endtask : check
    task automatic results();
        $display("checks %0d, errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results
    always @(posedge clk) begin
        if (rx_valid) begin
            check("read byte", rx,
                exp_q.size() ? exp_q.pop_front() : 8'hXX);
        end
    end
    task automatic open(input logic [7:0] op, input logic m);
        u_snp_spi_master.start(m);
        u_snp_spi_master.xfer(op, 1'b0);
    endtask : open
    task automatic close(input logic m);
        u_snp_spi_master.stop();
        check("output enable", {7'h00, so_oe}, 8'h00);
        check("mode flag", {7'h00, mode3}, {7'h00, m});
    endtask : close
    task automatic set_latch();
        open(`SNP_OP_SET_LATCH, 1'b0);
        close(1'b0);
        write_enable_latch = 1'b1;
    endtask : set_latch
    task automatic stat_rd(input logic [7:0] want);
        open(`SNP_OP_RD_STAT, 1'b1);
        exp_q.push_back(want);
        u_snp_spi_master.xfer(8'($urandom), 1'b1);
        close(1'b1);
        check("status port", status, want);
    endtask : stat_rd
    task automatic stat_wr(input logic [7:0] v);
        open(`SNP_OP_WR_STAT, 1'b0);
        u_snp_spi_master.xfer(v, 1'b0);
        close(1'b0);
        if (write_enable_latch && wp_n) begin
            bp = v[3:2];
        end
        write_enable_latch = 1'b0;
    endtask : stat_wr
    function automatic logic prot(input logic [8:0] a);
        return (bp == 2'h3) || (bp == 2'h2 && a >= 9'h100) ||
            (bp == 2'h1 && a >= 9'h180);
    endfunction : prot
    // One pause is placed after the first byte of every burst.
    task automatic mem_op(input logic rd, input logic [8:0] a, input int n,
        input logic m);
        logic [7:0] d;
        logic [7:0] op;
        logic halt;
        halt = 1'b0;
        op = {4'h0, a[8], rd ? `SNP_OP_MEM_RD : `SNP_OP_MEM_WR};
        open(op, m);
        u_snp_spi_master.xfer(a[7:0], 1'b0);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            if (rd) begin
                exp_q.push_back(mem[a]);
            end else if (write_enable_latch && wp_n && !halt) begin
                halt = prot(a);
                if (!halt) begin
                    mem[a] = d;
                end
            end
            if (i == 1) begin
                u_snp_spi_master.hold(3);
            end
            u_snp_spi_master.xfer(d, rd);
            if (!halt) begin
                a = a + 9'h001;
            end
        end
        close(m);
        if (!rd) begin
            write_enable_latch = 1'b0;
        end
    endtask : mem_op
    initial begin
        logic [8:0] base;
        base = 9'($urandom(72));
        repeat (16) @(posedge clk);
        #2;
        rst_n = 1'b1;
        check("status port", status, 8'h00);
        stat_rd(8'h00);
        set_latch();
        stat_rd(8'h02);
        open(`SNP_OP_CLR_LATCH, 1'b0);
        close(1'b0);
        write_enable_latch = 1'b0;
        stat_rd(8'h00);
        stat_wr(8'h0C);
        stat_rd(8'h00);
        wp_n = 1'b0;
        set_latch();
        stat_wr(8'h0C);
        wp_n = 1'b1;
        stat_rd(8'h00);
        set_latch();
        stat_wr(8'hFF);
        stat_rd(8'h0C);
        set_latch();
        stat_wr(8'h00);
        set_latch();
        mem_op(1'b0, 9'h1FE, 4, 1'b0);
        mem_op(1'b1, 9'h1FE, 4, 1'b1);
        for (int f = 0; f < 2; f++) begin
            set_latch();
            mem_op(1'b0, f ? 9'h17C : 9'h0FC, 8, 1'b0);
        end
        for (int k = 0; k < 6; k++) begin
            set_latch();
            stat_wr({4'h0, k < 4 ? 2'(k) : 2'h0, 2'h0});
            base = (k == 2) ? 9'h0FE : 9'h17E;
            wp_n = (k != 5);
            if (k != 4) begin
                set_latch();
            end
            mem_op(1'b0, base, 4, 1'b0);
            wp_n = 1'b1;
            mem_op(1'b1, base - 9'h002, 8, k[0]);
        end
        open(8'hFF, 1'b0);
        u_snp_spi_master.xfer(8'($urandom), 1'b0);
        check("invalid opcode enable", {7'h00, so_oe}, 8'h00);
        close(1'b0);
        check("pending reads", 8'(exp_q.size()), 8'h00);
        results();
    end
    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        results();
    end
endmodule : tb
